// file: logic/rafc_pkg.sv
// Package: register map, field positions, reset values and thresholds for rx auto flow control
`default_nettype none
package rafc_pkg;
  // Register word indices (byte address on Avalon-MM is index times four)
  localparam logic [7:0] IDX_MODE_PTR     = 8'h00;  // Legacy mode-register pointer window
  localparam logic [7:0] IDX_MODE_ONE     = 8'h21;  // Direct extended-map address
  localparam logic [7:0] IDX_FIFO_MODE    = 8'h20;  // fifo_mode_register
  localparam logic [7:0] IDX_COMMAND      = 8'h2A;  // Command register
  localparam logic [7:0] IDX_OUT_PORT     = 8'h2B;  // output_port_bits
  localparam logic [7:0] IDX_PORT_CFG     = 8'h2C;  // Port pin function select
  localparam logic [7:0] IDX_RX_STATUS    = 8'h2D;  // Flow status and fill level bit 8 (read)
  localparam logic [7:0] IDX_RX_FILL      = 8'h2E;  // Rx fill level, low 8 bits (read)
  localparam int         ADDR_W           = 10;
  // Field positions
  localparam int BIT_AUTO_FLOW  = 7;  // rx_auto_flow_enable in mode_register_one
  localparam int BIT_FIFO_DEPTH = 3;  // fifo_depth_select in fifo_mode_register
  localparam int BIT_OPR_RTS    = 0;  // output_port_bits: 1 asserts request-to-send
  localparam int BIT_CFG_RTS    = 0;  // port_config_bit: 0 gives pin two the RTS function
  // Command codes (command register, high nibble)
  localparam logic [3:0] CMD_RTS_ASSERT = 4'h8;
  localparam logic [3:0] CMD_RTS_NEGATE = 4'h9;
  localparam logic [3:0] CMD_PTR_RESET  = 4'h1;  // Point legacy window at fifo_mode_register
  // Thresholds
  localparam logic [8:0] FILL_LARGE_LIMIT = 9'h0F0;  // 240 characters
  localparam logic [8:0] FILL_SMALL_LIMIT = 9'h008;  // Position 8, FIFO full
  // Reset values
  localparam logic [7:0] RST_MODE_ONE  = 8'h00;
  localparam logic [7:0] RST_FIFO_MODE = 8'h00;
  localparam logic [7:0] RST_OUT_PORT  = 8'h00;
  localparam logic [7:0] RST_PORT_CFG  = 8'h01;  // Pin two starts as general I/O
  localparam logic [7:0] RST_PIN_GPIO  = 8'h00;
  // Avalon read latency on this slave: one waitrequest cycle
  localparam logic [1:0] BUS_WAIT_CYCLES = 2'h1;
endpackage : rafc_pkg
`default_nettype wire

// file: logic/rafc_flow_ctl.sv
// Receiver flow decision: negates request-to-send on start bit at or above the fill limit
`default_nettype none
module rafc_flow_ctl (
  input  wire logic       sys_clk,
  input  wire logic       rst_sync_b,
  input  wire logic       auto_en,
  input  wire logic       depth_large,
  input  wire logic       start_bit,
  input  wire logic [8:0] rx_fill,
  output logic            auto_negated
);
  typedef struct packed {
    logic negated;
  } rafc_flow_s;

  rafc_flow_s st_r;
  rafc_flow_s st_nxt;
  logic [8:0] limit;

  // Small FIFO trips only when full; large FIFO leaves 16 slots of headroom
  assign limit = depth_large ? rafc_pkg::FILL_LARGE_LIMIT
                             : rafc_pkg::FILL_SMALL_LIMIT;

  // Negate only at a valid start bit, so a character in flight is never cut off
  always_comb begin
    st_nxt = st_r;
    if (!auto_en) begin
      st_nxt.negated = 1'b0;
    end else if (start_bit && rx_fill >= limit) begin
      st_nxt.negated = 1'b1;
    end else if (rx_fill < limit) begin
      st_nxt.negated = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign auto_negated = st_r.negated;

  property p_negate_on_start;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (auto_en && start_bit && rx_fill >= limit) |=> auto_negated;
  endproperty
  a_negate_on_start: assert property (p_negate_on_start)
    else $error("auto flow did not negate at start bit above limit");

  property p_reassert_below;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (auto_en && rx_fill < limit) |=> !auto_negated;
  endproperty
  a_reassert_below: assert property (p_reassert_below)
    else $error("auto flow stayed negated below limit");

  property p_no_negate_without_start;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (!auto_negated && !start_bit) |=> !auto_negated;
  endproperty
  a_no_negate_without_start: assert property (p_no_negate_without_start)
    else $error("auto flow negated without a start bit");

  property p_small_limit;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (auto_en && !depth_large && start_bit && rx_fill == 9'h007) |=> !auto_negated;
  endproperty
  a_small_limit: assert property (p_small_limit)
    else $error("small fifo negated before full");

  c_negate: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
    !auto_negated ##1 auto_negated);
  c_reassert: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
    auto_negated ##1 !auto_negated);
endmodule : rafc_flow_ctl // rafc_flow_ctl
`default_nettype wire

// file: logic/rafc_top.sv
// Top: Avalon-MM register slave and request-to-send pin control with auto flow
//
// Implementation choice: the Avalon-MM register port.
`default_nettype none
module rafc_top (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire logic [rafc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        rx_start_bit,
  input  wire logic [8:0]                  rx_fill_level,
  input  wire logic                        inband_flow_en,
  input  wire logic                        port_pin_two_in,
  output logic                             port_pin_two_out,
  output logic                             port_pin_two_oe,
  output logic                             request_to_send_out_n
);
  typedef struct packed {
    logic [7:0]  mode_one;
    logic [7:0]  fifo_mode;
    logic [7:0]  out_port;
    logic [7:0]  port_cfg;
    logic        ptr_at_one;   // Legacy window: 0 -> fifo mode, 1 -> mode one
    logic        ack;          // Drops waitrequest for one cycle
    logic [31:0] rdata;
    logic        pin_out;
    logic        pin_oe;
    logic        rts_n;
  } rafc_top_s;

  rafc_top_s   st_r;
  rafc_top_s   st_nxt;
  logic [1:0]  rst_sync;
  logic        rst_sync_b;
  logic        auto_negated;
  logic        req;
  logic [7:0]  word_idx;
  logic [7:0]  wbyte;
  logic        rts_func;
  logic        rts_level_n;
  logic        wr_hit;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_sync[1];

  // Receiver-side decision lives in its own module
  rafc_flow_ctl u_flow (
    .sys_clk      (sys_clk),
    .rst_sync_b   (rst_sync_b),
    .auto_en      (st_r.mode_one[rafc_pkg::BIT_AUTO_FLOW] && rts_func),
    .depth_large  (st_r.fifo_mode[rafc_pkg::BIT_FIFO_DEPTH]),
    .start_bit    (rx_start_bit),
    .rx_fill      (rx_fill_level),
    .auto_negated (auto_negated)
  );

  // Word index: byte address divided by four; only byte lane 0 carries write data
  assign word_idx = avs_address[rafc_pkg::ADDR_W-1:2];
  assign wbyte    = avs_writedata[7:0];
  assign req      = (avs_read || avs_write) && !st_r.ack;
  assign wr_hit   = req && avs_write && avs_byteenable[0];  // Write that will land this edge
  assign rts_func = (st_r.port_cfg[rafc_pkg::BIT_CFG_RTS] == 1'b0);

  // Software asserts via port bit; auto flow can only negate, never assert.
  // In-band flow is a separate input and deliberately not interlocked here.
  assign rts_level_n = !st_r.out_port[rafc_pkg::BIT_OPR_RTS] || auto_negated;

  // Register file, command decode and pin drive
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = req;
    if (req && avs_write && avs_byteenable[0]) begin
      case (word_idx)
        rafc_pkg::IDX_MODE_ONE: begin
          st_nxt.mode_one = wbyte;
        end
        rafc_pkg::IDX_MODE_PTR: begin
          // Legacy window: first write hits fifo mode, then mode one
          if (st_r.ptr_at_one) begin
            st_nxt.mode_one = wbyte;
          end else begin
            st_nxt.fifo_mode  = wbyte;
            st_nxt.ptr_at_one = 1'b1;
          end
        end
        rafc_pkg::IDX_FIFO_MODE: begin
          st_nxt.fifo_mode = wbyte;
        end
        rafc_pkg::IDX_OUT_PORT: begin
          st_nxt.out_port = wbyte;
        end
        rafc_pkg::IDX_PORT_CFG: begin
          st_nxt.port_cfg = wbyte;
        end
        rafc_pkg::IDX_COMMAND: begin
          case (wbyte[7:4])
            rafc_pkg::CMD_RTS_ASSERT: st_nxt.out_port[rafc_pkg::BIT_OPR_RTS] = 1'b1;
            rafc_pkg::CMD_RTS_NEGATE: st_nxt.out_port[rafc_pkg::BIT_OPR_RTS] = 1'b0;
            rafc_pkg::CMD_PTR_RESET:  st_nxt.ptr_at_one = 1'b0;
            default:                  st_nxt.ptr_at_one = st_r.ptr_at_one;
          endcase
        end
        default: begin
          st_nxt.ptr_at_one = st_r.ptr_at_one;  // Unmapped writes are dropped
        end
      endcase
    end
    if (req && avs_read) begin
      case (word_idx)
        rafc_pkg::IDX_MODE_ONE:  st_nxt.rdata = {24'h00_0000, st_r.mode_one};
        rafc_pkg::IDX_MODE_PTR:  st_nxt.rdata = {24'h00_0000, st_r.ptr_at_one ?
                                               st_r.mode_one : st_r.fifo_mode};
        rafc_pkg::IDX_FIFO_MODE: st_nxt.rdata = {24'h00_0000, st_r.fifo_mode};
        rafc_pkg::IDX_OUT_PORT:  st_nxt.rdata = {24'h00_0000, st_r.out_port};
        rafc_pkg::IDX_PORT_CFG:  st_nxt.rdata = {24'h00_0000, st_r.port_cfg};
        rafc_pkg::IDX_RX_STATUS: st_nxt.rdata = {20'h0_0000, port_pin_two_in, inband_flow_en,
                                               st_r.rts_n, auto_negated, 7'h00, rx_fill_level[8]};
        rafc_pkg::IDX_RX_FILL:   st_nxt.rdata = {24'h00_0000, rx_fill_level[7:0]};
        default:                 st_nxt.rdata = 32'h0000_0000;  // Unmapped reads zero
      endcase
    end
    // Pin two drives RTS only when configured; otherwise it is a plain input
    st_nxt.rts_n   = rts_level_n;
    st_nxt.pin_oe  = rts_func;
    st_nxt.pin_out = rts_func ? rts_level_n : 1'b1;
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r.mode_one   <= rafc_pkg::RST_MODE_ONE;
      st_r.fifo_mode  <= rafc_pkg::RST_FIFO_MODE;
      st_r.out_port   <= rafc_pkg::RST_OUT_PORT;
      st_r.port_cfg   <= rafc_pkg::RST_PORT_CFG;
      st_r.ptr_at_one <= 1'b0;
      st_r.ack        <= 1'b0;
      st_r.rdata      <= 32'h0000_0000;
      st_r.pin_out    <= 1'b1;
      st_r.pin_oe     <= 1'b0;
      st_r.rts_n      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata          = st_r.rdata;
  assign avs_waitrequest       = !st_r.ack;
  assign port_pin_two_out      = st_r.pin_out;
  assign port_pin_two_oe       = st_r.pin_oe;
  assign request_to_send_out_n = st_r.rts_n;

  property p_mode_one_write;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (req && avs_write && avs_byteenable[0] && word_idx == rafc_pkg::IDX_MODE_ONE)
        |=> (st_r.mode_one == $past(wbyte));
  endproperty
  a_mode_one_write: assert property (p_mode_one_write)
    else $error("mode register one write lost");

  property p_auto_pin_high;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (auto_negated && rts_func) |=> (port_pin_two_out && request_to_send_out_n);
  endproperty
  a_auto_pin_high: assert property (p_auto_pin_high)
    else $error("pin not driven high while auto negated");

  property p_no_drive_gpio;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      !rts_func |=> !port_pin_two_oe;
  endproperty
  a_no_drive_gpio: assert property (p_no_drive_gpio)
    else $error("pin two driven while not assigned to RTS");

  property p_cmd_negate;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (req && avs_write && avs_byteenable[0] && word_idx == rafc_pkg::IDX_COMMAND
       && wbyte[7:4] == rafc_pkg::CMD_RTS_NEGATE) |=> ##1 request_to_send_out_n;
  endproperty
  a_cmd_negate: assert property (p_cmd_negate)
    else $error("negate command did not raise RTS");

  property p_auto_gated;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      !st_r.mode_one[rafc_pkg::BIT_AUTO_FLOW] |=> !auto_negated;
  endproperty
  a_auto_gated: assert property (p_auto_gated)
    else $error("auto flow active with enable clear");

  property p_ack_one_cycle;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle)
    else $error("waitrequest low for more than one cycle");

  // Legacy window: first write after pointer reset lands in fifo mode
  property p_ptr_first_write;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (wr_hit && word_idx == rafc_pkg::IDX_MODE_PTR && !st_r.ptr_at_one)
        |=> (st_r.fifo_mode == $past(wbyte) && st_r.ptr_at_one);
  endproperty
  a_ptr_first_write: assert property (p_ptr_first_write)
    else $error("legacy window first write missed fifo mode");

  property p_ptr_second_write;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (wr_hit && word_idx == rafc_pkg::IDX_MODE_PTR && st_r.ptr_at_one)
        |=> (st_r.mode_one == $past(wbyte));
  endproperty
  a_ptr_second_write: assert property (p_ptr_second_write)
    else $error("legacy window second write missed mode one");

  property p_ptr_reset_cmd;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (wr_hit && word_idx == rafc_pkg::IDX_COMMAND
       && wbyte[7:4] == rafc_pkg::CMD_PTR_RESET) |=> !st_r.ptr_at_one;
  endproperty
  a_ptr_reset_cmd: assert property (p_ptr_reset_cmd)
    else $error("pointer reset command ignored");

  property p_cmd_assert;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (wr_hit && word_idx == rafc_pkg::IDX_COMMAND
       && wbyte[7:4] == rafc_pkg::CMD_RTS_ASSERT) |=> st_r.out_port[rafc_pkg::BIT_OPR_RTS];
  endproperty
  a_cmd_assert: assert property (p_cmd_assert)
    else $error("assert command did not set port bit");

  property p_port_write;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (wr_hit && word_idx == rafc_pkg::IDX_OUT_PORT)
        |=> (st_r.out_port == $past(wbyte));
  endproperty
  a_port_write: assert property (p_port_write)
    else $error("output port write lost");

  // Software negation wins regardless of the receiver state
  property p_rts_follows_port;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      !st_r.out_port[rafc_pkg::BIT_OPR_RTS] |=> request_to_send_out_n;
  endproperty
  a_rts_follows_port: assert property (p_rts_follows_port)
    else $error("RTS asserted with port bit clear");

  property p_rts_asserted;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (st_r.out_port[rafc_pkg::BIT_OPR_RTS] && !auto_negated) |=> !request_to_send_out_n;
  endproperty
  a_rts_asserted: assert property (p_rts_asserted)
    else $error("RTS not driven low while asserted");

  property p_pin_is_rts;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      port_pin_two_oe |-> (port_pin_two_out == request_to_send_out_n);
  endproperty
  a_pin_is_rts: assert property (p_pin_is_rts)
    else $error("pin two level differs from RTS");

  property p_gpio_released_high;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      !port_pin_two_oe |-> port_pin_two_out;
  endproperty
  a_gpio_released_high: assert property (p_gpio_released_high)
    else $error("pin two output low while released");

  property p_read_mode_one;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      (req && avs_read && word_idx == rafc_pkg::IDX_MODE_ONE)
        |=> (avs_readdata == {24'h00_0000, $past(st_r.mode_one)});
  endproperty
  a_read_mode_one: assert property (p_read_mode_one)
    else $error("mode register one read wrong");

  property p_read_upper_zero;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      !avs_waitrequest |-> (avs_readdata[31:12] == 20'h0_0000);
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero)
    else $error("read data upper bits not zero");

  property p_auto_needs_rts_func;
    @(posedge sys_clk) disable iff (!rst_sync_b)
      !rts_func |=> !auto_negated;
  endproperty
  a_auto_needs_rts_func: assert property (p_auto_needs_rts_func)
    else $error("auto flow active while pin two is general I/O");

  c_cmd_assert: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
    request_to_send_out_n ##1 !request_to_send_out_n);
  c_both_flows: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
    auto_negated && inband_flow_en);
endmodule : rafc_top // rafc_top
`default_nettype wire

// file: bench/rafc_remote_tx_model.sv
// Remote transmitter model: paces characters by clear-to-send and tracks receive fill
`default_nettype none
module rafc_remote_tx_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       cts_in_n,
  input  wire logic       send_en,
  input  wire logic       drain,
  input  wire logic       load_en,
  input  wire logic [8:0] load_val,
  output logic            start_bit,
  output logic [8:0]      fill_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase_r;
  // A character lands four cycles after its start bit, so one is still in flight at a stop
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r    <= 3'h0;
      start_bit  <= 1'b0;
      fill_level <= 9'h000;
    end else begin
      start_bit <= 1'b0;
      if (load_en) fill_level <= load_val;
      else if (drain && fill_level != 9'h000) fill_level <= fill_level - 9'h001;
      else if (phase_r == 3'h4 && fill_level != 9'h100) fill_level <= fill_level + 9'h001;
      if (phase_r != 3'h0) phase_r <= phase_r + 3'h1;
      else if (send_en && !cts_in_n) begin  // Only start while clear-to-send is low
        start_bit <= 1'b1;
        phase_r   <= 3'h1;
      end
    end
  end
endmodule // rafc_remote_tx_model
`default_nettype wire

// file: bench/rafc_top_tb.sv
// Testbench for rafc_top: register access, command and automatic request-to-send control
`default_nettype none
module rafc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest, start_bit, inband_flow_en;
  logic pin_out, pin_oe, pin_in, rts_n, send_en, drain, load_en;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [8:0]  fill, load_val;
  int mismatches, total_checks, cyc;

  rafc_top rafc_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_start_bit(start_bit), .rx_fill_level(fill), .inband_flow_en(inband_flow_en),
    .port_pin_two_in(pin_in), .port_pin_two_out(pin_out), .port_pin_two_oe(pin_oe),
    .request_to_send_out_n(rts_n));
  rafc_remote_tx_model rafc_remote_tx_model_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .cts_in_n(rts_n), .send_en(send_en), .drain(drain), .load_en(load_en),
    .load_val(load_val), .start_bit(start_bit), .fill_level(fill));
  // Pin two has a pull-up when nobody drives it
  assign pin_in = pin_oe ? pin_out : 1'b1;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One bus cycle; request held until waitrequest is seen low, then an idle edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", 32'h0000_0000, {31'h0, avs_waitrequest});
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(nm, exp, rd);
  endtask

  // Bounded wait for the pin to settle at the expected level
  task automatic wait_rts(input logic exp);
    int n;
    n = 0;
    while (rts_n !== exp && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk("rts_n", {31'h0, exp}, {31'h0, rts_n});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Runaway guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    {rst_b, avs_read, avs_write, send_en, drain, load_en, inband_flow_en} = 7'h00;
    avs_address = 10'h000;
    avs_writedata = 32'h0000_0000;
    load_val = 9'h000;
    mismatches = 0;
    total_checks = 0;
    cyc = 0;
    idle(5);
    rst_b <= 1'b1;
    idle(3);
    chk("rts_n reset", 32'h0000_0001, {31'h0, rts_n});
    rdchk("fifo_mode", 8'h20, 32'h0000_0000);
    rdchk("mode_one", 8'h21, 32'h0000_0000);
    rdchk("port_cfg", 8'h2C, 32'h0000_0001);
    rdchk("unmapped", 8'h3F, 32'h0000_0000);
    // Legacy window: first write lands in fifo_mode, second in mode_one
    bus(1'b1, 8'h00, 8'h08);
    bus(1'b1, 8'h00, 8'h80);
    rdchk("fifo_mode ptr", 8'h20, 32'h0000_0008);
    rdchk("mode_one ptr", 8'h21, 32'h0000_0080);
    rdchk("window one", 8'h00, 32'h0000_0080);
    bus(1'b1, 8'h2A, 8'h10);
    rdchk("window fifo", 8'h00, 32'h0000_0008);
    bus(1'b1, 8'h2A, 8'h80);
    wait_rts(1'b0);
    chk("pin_oe gpio", 32'h0000_0000, {31'h0, pin_oe});
    // Pin still general I/O: a start at the 240 limit must not negate
    load_val <= 9'h0F0;
    load_en <= 1'b1;
    send_en <= 1'b1;
    @(posedge sys_clk);
    load_en <= 1'b0;
    idle(20);
    send_en <= 1'b0;
    chk("rts_n gpio", 32'h0000_0000, {31'h0, rts_n});
    load_val <= 9'h0EC;
    load_en <= 1'b1;
    inband_flow_en <= 1'b1;
    @(posedge sys_clk);
    load_en <= 1'b0;
    bus(1'b1, 8'h2C, 8'h00);
    chk("pin_oe rts", 32'h0000_0001, {31'h0, pin_oe});
    chk("pin_out", 32'h0000_0000, {31'h0, pin_out});
    // Sender runs up to 240, is stopped by the start at 240, last character lands
    send_en <= 1'b1;
    wait_rts(1'b1);
    idle(30);
    chk("fill stopped", 32'h0000_00F1, {23'h0, fill});
    chk("pin_out neg", 32'h0000_0001, {31'h0, pin_out});
    rdchk("status", 8'h2D, 32'h0000_0F00);
    rdchk("fill lo", 8'h2E, 32'h0000_00F1);
    send_en <= 1'b0;
    drain <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    drain <= 1'b0;
    wait_rts(1'b0);
    // Small FIFO: trigger at position 8
    load_val <= 9'h006;
    load_en <= 1'b1;
    @(posedge sys_clk);
    load_en <= 1'b0;
    bus(1'b1, 8'h20, 8'h00);
    send_en <= 1'b1;
    wait_rts(1'b1);
    idle(30);
    send_en <= 1'b0;
    chk("fill small", 32'h0000_0009, {23'h0, fill});
    bus(1'b1, 8'h21, 8'h00);
    wait_rts(1'b0);
    bus(1'b1, 8'h2A, 8'h90);
    wait_rts(1'b1);
    bus(1'b1, 8'h2B, 8'h01);
    wait_rts(1'b0);
    final_report();
  end
endmodule // rafc_top_tb
`default_nettype wire
